// [cfb_defs.vh]
// constants for the configuration fuse and protection bank
`ifndef CFB_DEFS_VH
`define CFB_DEFS_VH
// ---------------------------------------------------------------
// byte addresses in configuration space (22-bit table pointer)
// ---------------------------------------------------------------
`define CFB_ADDR_PIN_MUX 22'h300005
`define CFB_ADDR_DEBUG_ISA_BOOT 22'h300006
`define CFB_ADDR_CP_BLOCKS 22'h300008
`define CFB_ADDR_CP_DATA_BOOT 22'h300009
`define CFB_ADDR_WP_BLOCKS 22'h30000A
`define CFB_ADDR_WP_DATA_BOOT_CFG 22'h30000B
`define CFB_ADDR_TRP_BLOCKS 22'h30000C
`define CFB_ADDR_TRP_BOOT 22'h30000D
`define CFB_ADDR_ID_LOW 22'h3FFFFE
`define CFB_ADDR_ID_HIGH 22'h3FFFFF
// ---------------------------------------------------------------
// implemented-bit masks
// ---------------------------------------------------------------
`define CFB_MASK_PIN_MUX 8'h89
`define CFB_MASK_DEBUG_ISA_BOOT 8'hF1
`define CFB_MASK_LOW2 8'h03
`define CFB_MASK_HIGH2 8'hC0
`define CFB_MASK_HIGH3 8'hE0
`define CFB_MASK_BIT6 8'h40
// ---------------------------------------------------------------
// unprogrammed values
// ---------------------------------------------------------------
`define CFB_RST_PIN_MUX 8'h81
`define CFB_RST_DEBUG_ISA_BOOT 8'h81
`define CFB_RST_LOW2 8'h03
`define CFB_RST_HIGH2 8'hC0
`define CFB_RST_HIGH3 8'hE0
`define CFB_RST_BIT6 8'h40
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define CFB_BIT_RESET_PIN 7
`define CFB_BIT_TIMER_OSC 3
`define CFB_BIT_FAULT 0
`define CFB_BIT_DEBUG_N 7
`define CFB_BIT_XISA 6
`define CFB_BIT_BOOT_HI 5
`define CFB_BIT_BOOT_LO 4
`define CFB_BIT_STACK 0
`define CFB_BIT_DATA 7
`define CFB_BIT_BOOT 6
`define CFB_BIT_CFG 5
// ---------------------------------------------------------------
// boot block size codes and self-timed write length
// ---------------------------------------------------------------
`define CFB_BOOT_256W 2'h0
`define CFB_BOOT_512W 2'h1
`define CFB_BOOT_1KW 2'h2
`define CFB_WRITE_TIME_US 1000
`define CFB_CLK_MHZ 10
`define CFB_WRITE_CYCLES (`CFB_WRITE_TIME_US * `CFB_CLK_MHZ)
`endif

// [cfb_write_timer.v]
// self-timed long write sequencer for one configuration byte
`include "cfb_defs.vh"
module cfb_write_timer #(
  parameter WRITE_CYCLES = `CFB_WRITE_CYCLES
) (
  // clock and reset
  input wire core_clk,
  input wire rstn,
  // control
  input wire start,
  output wire busy,
  output wire done
);
  // ---------------------------------------------------------------
  // countdown
  // ---------------------------------------------------------------
  reg [15:0] cnt_q; // cycles left in the write
  reg done_q; // one-cycle completion pulse
  assign busy = (cnt_q != 16'h0000);
  assign done = done_q;
  // load on start, count down, pulse at the end
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_q <= 16'h0000;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= (cnt_q == 16'h0001);
      if (start && !busy)
        cnt_q <= WRITE_CYCLES[15:0];
      else if (busy)
        cnt_q <= cnt_q - 16'h0001;
    end
  end
endmodule // cfb_write_timer

// [cfb_bank.v]
// configuration fuse, protection and identification bank
`include "cfb_defs.vh"
module cfb_bank #(
  parameter LARGE_MEMORY = 1'b1,
  parameter [10:0] PART_ID = 11'h0AA, // arbitrary value
  parameter [4:0] SILICON_REV = 5'h01, // arbitrary value
  parameter WRITE_CYCLES = `CFB_WRITE_CYCLES
) (
  // clock and reset
  input wire core_clk,
  input wire rstn,
  // table read / write path
  input wire [21:0] tbl_addr,
  input wire [7:0] tbl_wdata,
  input wire tbl_write_start,
  input wire programming_mode,
  output wire tbl_write_busy,
  output wire tbl_write_done,
  output reg [7:0] tbl_rdata,
  // table read protection check
  input wire [1:0] exec_block,
  input wire [1:0] target_block,
  output reg table_read_allowed,
  // stack error
  input wire stack_error,
  output wire stack_reset_req,
  // pins seen from outside
  input wire port_a_pin5,
  input wire port_a_pin7,
  output wire external_reset_input,
  output wire port_a_pin5_input_en,
  output wire timer_osc_on_port_a_pin6,
  output wire timer_osc_on_port_b_pin2,
  output wire pwm_fault_input,
  output wire debugger_active,
  output wire port_b_pin6_pin7_gpio,
  output wire extended_isa_enable,
  output wire indexed_addr_enable,
  output reg [10:0] boot_block_words,
  // protection summary
  output wire [1:0] code_protect_block,
  output wire code_protect_data_mem,
  output wire code_protect_boot,
  output wire [1:0] write_protect_block,
  output wire write_protect_data_mem,
  output wire write_protect_boot,
  output wire write_protect_config
);
  // ---------------------------------------------------------------
  // bank storage
  // ---------------------------------------------------------------
  reg [7:0] pin_mux_config_q; // pin multiplexing
  reg [7:0] debug_isa_boot_config_q; // debug, isa, boot size, stack
  reg [7:0] code_protect_blocks_q; // block code protection
  reg [7:0] code_protect_data_boot_q; // data/boot code protection
  reg [7:0] write_protect_blocks_q; // block write protection
  reg [7:0] write_protect_data_boot_cfg_q; // data/boot/config write protection
  reg [7:0] table_read_protect_blocks_q; // block table-read protection
  reg [7:0] table_read_protect_boot_q; // boot table-read protection
  reg [21:0] wr_addr_q; // address latched at write start
  reg [7:0] wr_data_q; // data latched at write start
  reg [1:0] pa5_sync_q; // synchroniser for port A pin 5
  reg [1:0] pa7_sync_q; // synchroniser for port A pin 7
  wire timer_busy;
  wire timer_done;
  wire start_ok;

  // clearable bits only: new value may only drop ones
  function [7:0] clear_only;
    input [7:0] cur;
    input [7:0] wr;
    input [7:0] mask;
    begin
      clear_only = cur & (wr | ~mask) & mask;
    end
  endfunction

  // ---------------------------------------------------------------
  // write sequencing
  // ---------------------------------------------------------------
  // self-timed byte write
  cfb_write_timer #(
    .WRITE_CYCLES(WRITE_CYCLES)
  ) u_timer (
    .core_clk(core_clk),
    .rstn(rstn),
    .start(start_ok),
    .busy(timer_busy),
    .done(timer_done)
  );
  // a config write is refused while config is write-protected, unless programming_mode is set
  assign start_ok = tbl_write_start && !timer_busy &&
                    (write_protect_data_boot_cfg_q[`CFB_BIT_CFG] || programming_mode);
  assign tbl_write_busy = timer_busy;
  assign tbl_write_done = timer_done;

  // capture address and data as the write starts
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_addr_q <= 22'h000000;
      wr_data_q <= 8'h00;
    end
    else if (start_ok)
    begin
      wr_addr_q <= tbl_addr;
      wr_data_q <= tbl_wdata;
    end
  end

  // commit the byte when the timer finishes
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_mux_config_q <= `CFB_RST_PIN_MUX;
      debug_isa_boot_config_q <= `CFB_RST_DEBUG_ISA_BOOT;
      code_protect_blocks_q <= `CFB_RST_LOW2;
      code_protect_data_boot_q <= `CFB_RST_HIGH2;
      write_protect_blocks_q <= `CFB_RST_LOW2;
      write_protect_data_boot_cfg_q <= `CFB_RST_HIGH3;
      table_read_protect_blocks_q <= `CFB_RST_LOW2;
      table_read_protect_boot_q <= `CFB_RST_BIT6;
    end
    else if (timer_done)
    begin
      case (wr_addr_q)
        // settings bytes take ones and zeros
        `CFB_ADDR_PIN_MUX:
          pin_mux_config_q <= wr_data_q & `CFB_MASK_PIN_MUX;
        // bit 3 is masked off, stored as zero regardless
        `CFB_ADDR_DEBUG_ISA_BOOT:
          debug_isa_boot_config_q <= wr_data_q & `CFB_MASK_DEBUG_ISA_BOOT;
        // protection bits can only be cleared
        `CFB_ADDR_CP_BLOCKS:
          code_protect_blocks_q <=
            clear_only(code_protect_blocks_q, wr_data_q, `CFB_MASK_LOW2);
        `CFB_ADDR_CP_DATA_BOOT:
          code_protect_data_boot_q <=
            clear_only(code_protect_data_boot_q, wr_data_q, `CFB_MASK_HIGH2);
        `CFB_ADDR_WP_BLOCKS:
          write_protect_blocks_q <=
            clear_only(write_protect_blocks_q, wr_data_q, `CFB_MASK_LOW2);
        // config protect bit only moves in programming mode
        `CFB_ADDR_WP_DATA_BOOT_CFG:
        begin
          write_protect_data_boot_cfg_q[7:6] <=
            write_protect_data_boot_cfg_q[7:6] & wr_data_q[7:6];
          if (programming_mode)
            write_protect_data_boot_cfg_q[`CFB_BIT_CFG] <=
              write_protect_data_boot_cfg_q[`CFB_BIT_CFG] & wr_data_q[`CFB_BIT_CFG];
        end
        `CFB_ADDR_TRP_BLOCKS:
          table_read_protect_blocks_q <=
            clear_only(table_read_protect_blocks_q, wr_data_q, `CFB_MASK_LOW2);
        `CFB_ADDR_TRP_BOOT:
          table_read_protect_boot_q <=
            clear_only(table_read_protect_boot_q, wr_data_q, `CFB_MASK_BIT6);
        // id bytes and unmapped addresses ignore writes
        default:
        begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // unimplemented bits and unmapped bytes read zero
  always @*
  begin
    case (tbl_addr)
      `CFB_ADDR_PIN_MUX: tbl_rdata = pin_mux_config_q;
      `CFB_ADDR_DEBUG_ISA_BOOT: tbl_rdata = debug_isa_boot_config_q;
      `CFB_ADDR_CP_BLOCKS: tbl_rdata = code_protect_blocks_q;
      `CFB_ADDR_CP_DATA_BOOT: tbl_rdata = code_protect_data_boot_q;
      `CFB_ADDR_WP_BLOCKS: tbl_rdata = write_protect_blocks_q;
      `CFB_ADDR_WP_DATA_BOOT_CFG: tbl_rdata = write_protect_data_boot_cfg_q;
      `CFB_ADDR_TRP_BLOCKS: tbl_rdata = table_read_protect_blocks_q;
      `CFB_ADDR_TRP_BOOT: tbl_rdata = table_read_protect_boot_q;
      `CFB_ADDR_ID_LOW: tbl_rdata = {PART_ID[2:0], SILICON_REV};
      `CFB_ADDR_ID_HIGH: tbl_rdata = PART_ID[10:3];
      default: tbl_rdata = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // pin multiplexing
  // ---------------------------------------------------------------
  // pins come from outside the clock domain
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pa5_sync_q <= 2'h3;
      pa7_sync_q <= 2'h3;
    end
    else
    begin
      pa5_sync_q <= {pa5_sync_q[0], port_a_pin5};
      pa7_sync_q <= {pa7_sync_q[0], port_a_pin7};
    end
  end
  // shared pin is reset or port input
  assign external_reset_input = pin_mux_config_q[`CFB_BIT_RESET_PIN] ? pa5_sync_q[1] : 1'b1;
  assign port_a_pin5_input_en = ~pin_mux_config_q[`CFB_BIT_RESET_PIN];
  assign timer_osc_on_port_a_pin6 = pin_mux_config_q[`CFB_BIT_TIMER_OSC];
  assign timer_osc_on_port_b_pin2 = ~pin_mux_config_q[`CFB_BIT_TIMER_OSC];
  assign pwm_fault_input = pin_mux_config_q[`CFB_BIT_FAULT] ? pa5_sync_q[1] : pa7_sync_q[1];

  // ---------------------------------------------------------------
  // debug, isa, boot block, stack
  // ---------------------------------------------------------------
  // debugger takes B6/B7 when bit is low
  assign debugger_active = ~debug_isa_boot_config_q[`CFB_BIT_DEBUG_N];
  assign port_b_pin6_pin7_gpio = debug_isa_boot_config_q[`CFB_BIT_DEBUG_N];
  assign extended_isa_enable = debug_isa_boot_config_q[`CFB_BIT_XISA];
  assign indexed_addr_enable = debug_isa_boot_config_q[`CFB_BIT_XISA];
  assign stack_reset_req = stack_error & debug_isa_boot_config_q[`CFB_BIT_STACK];

  always @*
  begin
    case (debug_isa_boot_config_q[`CFB_BIT_BOOT_HI:`CFB_BIT_BOOT_LO])
      2'h0: boot_block_words = 11'h100;
      2'h1: boot_block_words = 11'h200;
      default: boot_block_words = LARGE_MEMORY ? 11'h400 : 11'h200;
    endcase
  end

  // ---------------------------------------------------------------
  // protection outputs (stored zero means protected, output driven high)
  // ---------------------------------------------------------------
  // code protection and block write protection
  assign code_protect_block = ~code_protect_blocks_q[1:0];
  assign code_protect_data_mem = ~code_protect_data_boot_q[`CFB_BIT_DATA];
  assign code_protect_boot = ~code_protect_data_boot_q[`CFB_BIT_BOOT];
  assign write_protect_block = ~write_protect_blocks_q[1:0];
  // data, boot and config write protection
  assign write_protect_data_mem = ~write_protect_data_boot_cfg_q[`CFB_BIT_DATA];
  assign write_protect_boot = ~write_protect_data_boot_cfg_q[`CFB_BIT_BOOT];
  assign write_protect_config = ~write_protect_data_boot_cfg_q[`CFB_BIT_CFG];

  // table read check; block 2 stands for the boot block
  always @*
  begin
    table_read_allowed = 1'b1;
    if (exec_block != target_block)
    begin
      case (target_block)
        2'h0: table_read_allowed = table_read_protect_blocks_q[0];
        2'h1: table_read_allowed = table_read_protect_blocks_q[1];
        2'h2: table_read_allowed = table_read_protect_boot_q[`CFB_BIT_BOOT];
        default: table_read_allowed = 1'b1;
      endcase
    end
  end
endmodule // cfb_bank

// [cfb_checker.sv]
// port-level assertion checker for the configuration fuse bank
`include "cfb_defs.vh"
module cfb_checker #(
  parameter int WRITE_CYCLES = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // table path
  input wire logic [21:0] tbl_addr,
  input wire logic tbl_write_start,
  input wire logic programming_mode,
  input wire logic tbl_write_busy,
  input wire logic tbl_write_done,
  input wire logic [7:0] tbl_rdata,
  // table read check and stack
  input wire logic [1:0] exec_block,
  input wire logic [1:0] target_block,
  input wire logic table_read_allowed,
  input wire logic stack_error,
  input wire logic stack_reset_req,
  // decoded settings
  input wire logic external_reset_input,
  input wire logic port_a_pin5_input_en,
  input wire logic timer_osc_on_port_a_pin6,
  input wire logic timer_osc_on_port_b_pin2,
  input wire logic debugger_active,
  input wire logic port_b_pin6_pin7_gpio,
  input wire logic extended_isa_enable,
  input wire logic indexed_addr_enable,
  input wire logic [10:0] boot_block_words
);
  // one clock domain: shared clock and reset for every property
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // -------------------------------------------------------------
  // decoded outputs versus stored bytes and versus each other
  // -------------------------------------------------------------
  chk_reset_pin_mux: assert property ((tbl_addr == `CFB_ADDR_PIN_MUX) |->
    (tbl_rdata[7] != port_a_pin5_input_en) && (tbl_rdata[3] == timer_osc_on_port_a_pin6))
    else $error("pin mux outputs disagree with stored byte");
  chk_pin_release: assert property (port_a_pin5_input_en |-> external_reset_input)
    else $error("reset seen while pin is plain input");
  chk_timer_place: assert property (timer_osc_on_port_a_pin6 != timer_osc_on_port_b_pin2)
    else $error("timer pin placed twice or nowhere");
  chk_debug_pins: assert property (debugger_active != port_b_pin6_pin7_gpio)
    else $error("debug pins both shared and dedicated");
  chk_isa_pair: assert property ((tbl_addr == `CFB_ADDR_DEBUG_ISA_BOOT) |->
    extended_isa_enable == tbl_rdata[6] && indexed_addr_enable == tbl_rdata[6])
    else $error("extension enables not tied to their bit");
  chk_boot_size: assert property ((tbl_addr == `CFB_ADDR_DEBUG_ISA_BOOT) |->
    boot_block_words == ((tbl_rdata[5:4] == 2'h0) ? 11'h100 :
    (tbl_rdata[5:4] == 2'h1) ? 11'h200 : 11'h400))
    else $error("boot block size decode wrong");
  chk_stack_reset: assert property ((tbl_addr == `CFB_ADDR_DEBUG_ISA_BOOT) |->
    stack_reset_req == (stack_error & tbl_rdata[0]))
    else $error("stack reset request wrong");
  chk_unused_zero: assert property ((tbl_addr == `CFB_ADDR_CP_BLOCKS) |->
    tbl_rdata[7:2] == 6'h00)
    else $error("unimplemented bits not zero");
  // -------------------------------------------------------------
  // protection behaviour over time
  // -------------------------------------------------------------
  chk_clear_only: assert property ((tbl_addr == `CFB_ADDR_CP_BLOCKS && $stable(tbl_addr)) |->
    (tbl_rdata[1:0] & ~$past(tbl_rdata[1:0])) == 2'h0)
    else $error("cleared protection bit came back");
  chk_cfg_wp_held: assert property ((tbl_addr == `CFB_ADDR_WP_DATA_BOOT_CFG &&
    $stable(tbl_addr) && !programming_mode && !$past(programming_mode)) |->
    tbl_rdata[5] == $past(tbl_rdata[5]))
    else $error("config write protect moved outside programming");
  chk_write_time: assert property ((tbl_write_start && !tbl_write_busy && programming_mode)
    |=> tbl_write_busy ##WRITE_CYCLES tbl_write_done)
    else $error("self-timed write length wrong");
  chk_same_block: assert property ((exec_block == target_block || target_block == 2'h3)
    |-> table_read_allowed)
    else $error("own-block table read refused");
endmodule // cfb_checker

bind cfb_bank cfb_checker #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (.core_clk(core_clk), .rstn(rstn),
  .tbl_addr(tbl_addr), .tbl_write_start(tbl_write_start), .programming_mode(programming_mode),
  .tbl_write_busy(tbl_write_busy), .tbl_write_done(tbl_write_done), .tbl_rdata(tbl_rdata),
  .exec_block(exec_block), .target_block(target_block), .table_read_allowed(table_read_allowed),
  .stack_error(stack_error), .stack_reset_req(stack_reset_req),
  .external_reset_input(external_reset_input), .port_a_pin5_input_en(port_a_pin5_input_en),
  .timer_osc_on_port_a_pin6(timer_osc_on_port_a_pin6),
  .timer_osc_on_port_b_pin2(timer_osc_on_port_b_pin2), .debugger_active(debugger_active),
  .port_b_pin6_pin7_gpio(port_b_pin6_pin7_gpio), .extended_isa_enable(extended_isa_enable),
  .indexed_addr_enable(indexed_addr_enable), .boot_block_words(boot_block_words));

// [test_config_fuse_protection_bank.sv]
// self-checking bench for the configuration fuse bank
`include "cfb_defs.vh"
module test_config_fuse_protection_bank;
  timeunit 1ns;
  timeprecision 1ns;
  // -------------------------------------------------------------
  // stimulus and observed signals
  // -------------------------------------------------------------
  localparam logic [10:0] PID = 11'h0AA; // arbitrary value
  localparam logic [4:0] REV = 5'h01; // arbitrary value
  logic core_clk, rstn, tbl_write_start, programming_mode, stack_error, pin5, pin7;
  logic [21:0] tbl_addr;
  logic [7:0] tbl_wdata;
  logic [1:0] exec_block, target_block;
  wire [7:0] rdata;
  wire busy, done, allowed, stk_req, ext_rst, pin5_in, osc_a6, osc_b2, fault_n, dbg, gpio;
  wire isa, idx, cp_d, cp_b, wp_d, wp_b, wp_c;
  wire [10:0] boot_words;
  wire [1:0] cp_blk, wp_blk;
  int bad_count = 0;
  int compares = 0;
  int i;
  // unprogrammed bytes, id bytes and one unmapped place
  logic [21:0] addr_t [11] = '{`CFB_ADDR_PIN_MUX, `CFB_ADDR_DEBUG_ISA_BOOT, `CFB_ADDR_CP_BLOCKS,
    `CFB_ADDR_CP_DATA_BOOT, `CFB_ADDR_WP_BLOCKS, `CFB_ADDR_WP_DATA_BOOT_CFG,
    `CFB_ADDR_TRP_BLOCKS, `CFB_ADDR_TRP_BOOT, `CFB_ADDR_ID_LOW, `CFB_ADDR_ID_HIGH, 22'h300007};
  logic [7:0] rst_t [11] = '{8'h81, 8'h81, 8'h03, 8'hC0, 8'h03, 8'hE0, 8'h03, 8'h40,
    {PID[2:0], REV}, PID[10:3], 8'h00};

  cfb_bank #(.LARGE_MEMORY(1'b1), .PART_ID(PID), .SILICON_REV(REV), .WRITE_CYCLES(4)) dut (
    .core_clk(core_clk), .rstn(rstn), .tbl_addr(tbl_addr), .tbl_wdata(tbl_wdata),
    .tbl_write_start(tbl_write_start), .programming_mode(programming_mode),
    .tbl_write_busy(busy), .tbl_write_done(done), .tbl_rdata(rdata),
    .exec_block(exec_block), .target_block(target_block), .table_read_allowed(allowed),
    .stack_error(stack_error), .stack_reset_req(stk_req), .port_a_pin5(pin5),
    .port_a_pin7(pin7), .external_reset_input(ext_rst), .port_a_pin5_input_en(pin5_in),
    .timer_osc_on_port_a_pin6(osc_a6), .timer_osc_on_port_b_pin2(osc_b2),
    .pwm_fault_input(fault_n), .debugger_active(dbg), .port_b_pin6_pin7_gpio(gpio),
    .extended_isa_enable(isa), .indexed_addr_enable(idx), .boot_block_words(boot_words),
    .code_protect_block(cp_blk), .code_protect_data_mem(cp_d), .code_protect_boot(cp_b),
    .write_protect_block(wp_blk), .write_protect_data_mem(wp_d), .write_protect_boot(wp_b),
    .write_protect_config(wp_c));

  // 10 MHz clock
  always #50 core_clk = ~core_clk;
  // -------------------------------------------------------------
  // access and compare tasks
  // -------------------------------------------------------------
  // one compare for every result, unknowns never match
  task automatic cmp(input logic [10:0] got, input logic [10:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // table read: address set on an edge, byte looked at mid-cycle
  task automatic rd(input logic [21:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    tbl_addr <= a;
    @(negedge core_clk);
    cmp(rdata, exp);
  endtask
  // one-cycle start, then bounded wait for the done pulse
  task automatic wr(input logic [21:0] a, input logic [7:0] d, input logic pm, input logic ok);
    int n;
    @(posedge core_clk);
    tbl_addr <= a;
    tbl_wdata <= d;
    programming_mode <= pm;
    tbl_write_start <= 1'b1;
    @(posedge core_clk);
    tbl_write_start <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20)
    begin
      @(negedge core_clk);
      n++;
    end
    // the byte lands on the edge after the done pulse
    @(posedge core_clk);
    @(negedge core_clk);
    cmp(n < 20, ok);
  endtask
  // let the two-flop pin synchronisers settle
  task automatic settle();
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  // verdict and end of run
  task automatic report_and_stop();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial
  begin
    {core_clk, rstn, tbl_write_start, programming_mode, stack_error} = 5'h00;
    {pin5, pin7, tbl_addr, tbl_wdata, exec_block, target_block} = '1;
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    for (i = 0; i < 11; i++) rd(addr_t[i], rst_t[i]);
    pin5 <= 1'b0;
    settle();
    cmp({pin5_in, ext_rst, osc_b2, fault_n}, 4'b0010);
    pin5 <= 1'b1;
    stack_error <= 1'b1;
    // boot size codes with isa, debugger and stack bits; bit 3 kept at zero
    for (i = 0; i < 4; i++)
    begin
      wr(`CFB_ADDR_DEBUG_ISA_BOOT, {1'b0, i[0], i[1:0], 3'b000, i[0]}, 1'b0, 1'b1);
      rd(`CFB_ADDR_DEBUG_ISA_BOOT, {1'b0, i[0], i[1:0], 3'b000, i[0]});
      cmp(boot_words, (i == 0) ? 11'h100 : (i == 1) ? 11'h200 : 11'h400);
      cmp({dbg, gpio, isa, idx, stk_req}, {2'b10, i[0], i[0], i[0]});
    end
    wr(`CFB_ADDR_PIN_MUX, 8'h08, 1'b0, 1'b1);
    pin5 <= 1'b0;
    pin7 <= 1'b0;
    settle();
    cmp({pin5_in, ext_rst, osc_a6, osc_b2, fault_n}, 5'b11100);
    pin7 <= 1'b1;
    settle();
    cmp(fault_n, 1'b1);
    wr(`CFB_ADDR_CP_BLOCKS, 8'h02, 1'b0, 1'b1);
    cmp(cp_blk, 2'b01);
    wr(`CFB_ADDR_CP_BLOCKS, 8'hFF, 1'b0, 1'b1);
    rd(`CFB_ADDR_CP_BLOCKS, 8'h02);
    wr(`CFB_ADDR_CP_DATA_BOOT, 8'h40, 1'b0, 1'b1);
    cmp({cp_d, cp_b}, 2'b10);
    wr(`CFB_ADDR_WP_BLOCKS, 8'h01, 1'b0, 1'b1);
    cmp(wp_blk, 2'b10);
    wr(`CFB_ADDR_TRP_BLOCKS, 8'h02, 1'b0, 1'b1);
    wr(`CFB_ADDR_TRP_BOOT, 8'h00, 1'b0, 1'b1);
    // exec/target pairs: cross reads of block0 and boot refused, other never
    for (i = 0; i < 5; i++)
    begin
      @(posedge core_clk);
      exec_block <= (i == 0 || i == 3) ? 2'h1 : 2'h0;
      target_block <= (i < 2) ? 2'h0 : (i == 2) ? 2'h1 : (i == 3) ? 2'h2 : 2'h3;
      @(negedge core_clk);
      cmp(allowed, (i == 1 || i == 2 || i == 4) ? 1'b1 : 1'b0);
    end
    wr(`CFB_ADDR_WP_DATA_BOOT_CFG, 8'h40, 1'b0, 1'b1);
    rd(`CFB_ADDR_WP_DATA_BOOT_CFG, 8'h60);
    cmp({wp_d, wp_b, wp_c}, 3'b100);
    wr(`CFB_ADDR_WP_DATA_BOOT_CFG, 8'h40, 1'b1, 1'b1);
    cmp(wp_c, 1'b1);
    wr(`CFB_ADDR_CP_BLOCKS, 8'h00, 1'b0, 1'b0);
    rd(`CFB_ADDR_CP_BLOCKS, 8'h02);
    report_and_stop();
  end
  // watchdog well beyond the expected few hundred cycles
  initial
  begin
    #500000;
    bad_count++;
    report_and_stop();
  end
endmodule // test_config_fuse_protection_bank
